// *** common/pc_ctx_pkg.sv ***
// Package with constants for the program counter and fast context block.
package pc_ctx_pkg;
    localparam int PC_WIDTH = 21;
    localparam int UPPER_WIDTH = 5;
    localparam int PHASE_WIDTH = 2;
    localparam logic [1:0] PHASE_ONE = 2'h0;
    localparam logic [1:0] PHASE_TWO = 2'h1;
    localparam logic [1:0] PHASE_THREE = 2'h2;
    localparam logic [1:0] PHASE_FOUR = 2'h3;
    localparam logic [20:0] PC_STEP = 21'h00_0002;
    localparam logic [20:0] PC_RESET = 21'h00_0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    // APB register map (byte addresses).
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'h00;
    localparam logic [7:0] ADDR_MIDDLE_LATCH = 8'h04;
    localparam logic [7:0] ADDR_UPPER_LATCH = 8'h08;
    localparam logic [7:0] ADDR_PC_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_INSTR = 8'h10;
    // Mask that keeps the word-aligned counter's low bit cleared.
    localparam logic [20:0] ALIGN_MASK = 21'h1F_FFFE;
endpackage

// *** rtl/fast_context_store.sv ***
// One-deep shadow store for status, working and bank select registers.
`timescale 1ns/10ps
module fast_context_store (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Save and restore controls
    input wire logic save_in,
    input wire logic restore_in,
    // Live register values
    input wire logic [7:0] status_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] bank_select_register_in,
    // Shadow values and restore strobe
    output logic [7:0] status_out,
    output logic [7:0] working_register_out,
    output logic [7:0] bank_select_register_out,
    output logic restore_valid_out
);
    // A single entry; every save overwrites it with no nesting.
    always_ff @(posedge clk_in) begin // [RULE1] [RULE5]
        if (!resetn_in) begin
            status_out <= pc_ctx_pkg::BYTE_ZERO;
            working_register_out <= pc_ctx_pkg::BYTE_ZERO;
            bank_select_register_out <= pc_ctx_pkg::BYTE_ZERO;
        end else if (save_in) begin
            status_out <= status_in;
            working_register_out <= working_register_in;
            bank_select_register_out <= bank_select_register_in;
        end
    end

    always_ff @(posedge clk_in) begin // [RULE4]
        if (!resetn_in) begin
            restore_valid_out <= 1'b0;
        end else begin
            restore_valid_out <= restore_in;
        end
    end

    chk_save_overwrites: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE5]
        save_in |=> working_register_out == $past(working_register_in))
        else $error("Shadow store did not take the new value.");
    chk_hold_idle: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE1]
        !save_in |=> $stable(status_out) && $stable(bank_select_register_out))
        else $error("Shadow store changed without a save.");
endmodule // fast_context_store

// *** rtl/pc_sequencer.sv ***
// Program counter sequencing with latches, phase clocks and fast context.
//
// Function
// RULE1: Shadow store is exactly one entry deep.
// RULE2: Software cannot read or write shadow store.
// RULE3: Interrupt vectoring saves status, working, bank registers.
// RULE4: Fast return restores them; plain return does not.
// RULE5: High priority entry overwrites low priority save.
// RULE6: Fast call saves; fast return restores.
// RULE7: Software saves registers when priorities nest.
// RULE8: Counter is 21 bits, byte addressed.
// RULE9: Only low byte accessible; upper bytes via latches.
// RULE10: Counter bit zero always reads zero.
// RULE11: Sequential execution advances by two.
// RULE12: Calls, jumps, branches load counter directly.
// RULE13: Low byte write loads upper bytes from latches.
// RULE14: Low byte read copies upper bytes into latches.
// RULE15: Clock divided by four into four phases.
// RULE16: Increment in phase one, latch instruction phase four.
// RULE17: Latched instruction executes during next cycle.
// RULE18: Reset clears counter and both latches.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
module pc_sequencer #(
    parameter int PC_BITS = pc_ctx_pkg::PC_WIDTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Core fetch and decode
    input wire logic [15:0] fetch_word_in,
    input wire logic load_pc_in,
    input wire logic [20:0] load_target_in,
    input wire logic irq_vector_in,
    input wire logic fast_call_in,
    input wire logic fast_return_in,
    // Live core registers
    input wire logic [7:0] status_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] bank_select_register_in,
    // Outputs to the core
    output logic [20:0] pc_out,
    output logic [15:0] instr_out,
    output logic [1:0] phase_out,
    output logic phase_one_out,
    output logic phase_four_out,
    output logic exec_valid_out,
    output logic restore_valid_out,
    output logic [7:0] restore_status_out,
    output logic [7:0] restore_working_out,
    output logic [7:0] restore_bank_out
);
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } phase_t;

    phase_t phase;
    phase_t next_phase;
    logic [20:0] pc;
    logic [7:0] middle_byte_latch;
    logic [4:0] upper_byte_latch;
    logic [15:0] instr;
    logic instr_valid;
    logic exec_valid;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ctx_save;
    logic ctx_restore;
    logic ctx_restore_valid;
    logic [7:0] ctx_status;
    logic [7:0] ctx_working;
    logic [7:0] ctx_bank;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
        addr_is = (a == target);
    endfunction

    // APB decode; the access phase takes two cycles, with pready raised in the second.
    wire apb_access = psel_in && penable_in && !pready;
    wire apb_wr = apb_access && pwrite_in;
    wire apb_rd = apb_access && !pwrite_in;
    wire hit_low = addr_is(paddr_in, pc_ctx_pkg::ADDR_COUNTER_LOW);
    wire hit_mid = addr_is(paddr_in, pc_ctx_pkg::ADDR_MIDDLE_LATCH);
    wire hit_up = addr_is(paddr_in, pc_ctx_pkg::ADDR_UPPER_LATCH);
    wire hit_stat = addr_is(paddr_in, pc_ctx_pkg::ADDR_PC_STATUS);
    wire hit_instr = addr_is(paddr_in, pc_ctx_pkg::ADDR_INSTR);
    wire hit_any = hit_low || hit_mid || hit_up || hit_stat || hit_instr;
    wire low_write = apb_wr && hit_low; // [RULE9]
    wire low_read = apb_rd && hit_low; // [RULE9]
    wire mid_write = apb_wr && hit_mid;
    wire up_write = apb_wr && hit_up;

    // Phase counter: input clock divided by four.
    always_comb begin // [RULE15]
        case (phase)
            PH_ONE: next_phase = PH_TWO;
            PH_TWO: next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            default: next_phase = PH_ONE;
        endcase
    end

    wire in_phase_one = (phase == PH_ONE);
    wire in_phase_four = (phase == PH_FOUR);

    // Counter source priority: low byte write, direct load, then increment.
    wire [20:0] latch_target = {upper_byte_latch, middle_byte_latch, pwdata_in[7:0]};
    wire [20:0] incremented = pc + pc_ctx_pkg::PC_STEP; // [RULE11]
    wire [20:0] next_pc_raw = low_write ? latch_target : // [RULE13]
        load_pc_in ? load_target_in : // [RULE12]
        in_phase_one ? incremented : pc; // [RULE16]
    wire [20:0] next_pc = next_pc_raw & pc_ctx_pkg::ALIGN_MASK; // [RULE10] [RULE8]

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            phase <= PH_ONE;
        end else begin
            phase <= next_phase;
        end
    end

    always_ff @(posedge clk_in) begin // [RULE18]
        if (!resetn_in) begin
            pc <= pc_ctx_pkg::PC_RESET;
        end else begin
            pc <= next_pc;
        end
    end

    // A low byte write outranks a direct load, which outranks the phase one step.
    chk_pc_aligned: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE10]
        pc[0] == 1'b0)
        else $error("Counter bit zero is set.");
    chk_pc_step: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE11]
        in_phase_one && !low_write && !load_pc_in |=> pc == $past(pc) + pc_ctx_pkg::PC_STEP)
        else $error("Counter did not advance by two.");
    chk_pc_hold: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE16]
        !in_phase_one && !low_write && !load_pc_in |=> $stable(pc))
        else $error("Counter moved outside phase one.");
    chk_direct_load: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE12]
        load_pc_in && !low_write |=> pc == ($past(load_target_in) & pc_ctx_pkg::ALIGN_MASK))
        else $error("Direct load did not reach the counter.");
    chk_low_write: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE13]
        low_write |=> pc[20:8] == {$past(upper_byte_latch), $past(middle_byte_latch)})
        else $error("Low byte write did not take the latches.");
    chk_low_full: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE13]
        low_write |=> pc == ($past(latch_target) & pc_ctx_pkg::ALIGN_MASK))
        else $error("Low byte write did not set the whole counter.");
    chk_reset_clear: assert property (@(posedge clk_in) // [RULE18]
        !resetn_in |=> pc == pc_ctx_pkg::PC_RESET && middle_byte_latch == pc_ctx_pkg::BYTE_ZERO
            && upper_byte_latch == '0)
        else $error("Reset did not clear counter and latches.");

    // Latches: software writes, or a low byte read copies the counter's upper bytes.
    always_ff @(posedge clk_in) begin // [RULE18]
        if (!resetn_in) begin
            middle_byte_latch <= pc_ctx_pkg::BYTE_ZERO;
            upper_byte_latch <= 5'h00;
        end else if (low_read) begin // [RULE14]
            middle_byte_latch <= pc[15:8];
            upper_byte_latch <= pc[20:16];
        end else begin
            if (mid_write) begin
                middle_byte_latch <= pwdata_in[7:0];
            end
            if (up_write) begin
                upper_byte_latch <= pwdata_in[4:0];
            end
        end
    end

    chk_low_read: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE14]
        low_read |=> {upper_byte_latch, middle_byte_latch} == $past(pc[20:8]))
        else $error("Low byte read did not copy upper bytes.");
    chk_latch_hold: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        !low_read && !mid_write && !up_write |=> $stable({upper_byte_latch, middle_byte_latch}))
        else $error("Latch changed without an access.");
    chk_mid_write: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        mid_write |=> middle_byte_latch == $past(pwdata_in[7:0]))
        else $error("Middle latch write was lost.");
    chk_up_write: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        up_write |=> upper_byte_latch == $past(pwdata_in[4:0]))
        else $error("Upper latch write was lost.");

    // Instruction register latched in phase four, executed during the next cycle.
    always_ff @(posedge clk_in) begin // [RULE16] [RULE17]
        if (!resetn_in) begin
            instr <= pc_ctx_pkg::WORD_ZERO;
            instr_valid <= 1'b0;
            exec_valid <= 1'b0;
        end else begin
            if (in_phase_four) begin
                instr <= fetch_word_in;
                instr_valid <= 1'b1;
            end
            exec_valid <= instr_valid;
        end
    end

    chk_fetch_q4: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE16]
        in_phase_four |=> instr == $past(fetch_word_in))
        else $error("Instruction not latched in phase four.");
    chk_instr_hold: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE16]
        !in_phase_four |=> $stable(instr))
        else $error("Instruction register changed outside phase four.");
    chk_instr_valid: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE16]
        in_phase_four |=> instr_valid)
        else $error("Latched instruction not flagged.");
    chk_exec_next: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE17]
        in_phase_four |=> ##1 exec_valid)
        else $error("Latched instruction not marked for execution.");
    chk_exec_follows: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE17]
        exec_valid == $past(instr_valid))
        else $error("Execution flag does not trail the latch flag.");

    // Shadow store has no bus path; only vectoring, fast call and return reach it.
    assign ctx_save = irq_vector_in || fast_call_in; // [RULE2] [RULE3] [RULE6]
    assign ctx_restore = fast_return_in; // [RULE4] [RULE6]

    fast_context_store u_ctx (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .save_in(ctx_save),
        .restore_in(ctx_restore),
        .status_in(status_in),
        .working_register_in(working_register_in),
        .bank_select_register_in(bank_select_register_in),
        .status_out(ctx_status),
        .working_register_out(ctx_working),
        .bank_select_register_out(ctx_bank),
        .restore_valid_out(ctx_restore_valid)
    );

    chk_irq_save: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE3]
        irq_vector_in |=> ctx_status == $past(status_in)
            && ctx_working == $past(working_register_in)
            && ctx_bank == $past(bank_select_register_in))
        else $error("Interrupt entry did not save context.");
    chk_fast_call: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE6]
        fast_call_in |=> ctx_status == $past(status_in)
            && ctx_working == $past(working_register_in)
            && ctx_bank == $past(bank_select_register_in))
        else $error("Fast call did not save context.");
    chk_fast_ret: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE4]
        fast_return_in |=> restore_valid_out)
        else $error("Fast return gave no restore strobe.");
    chk_plain_return: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE4]
        !fast_return_in |=> !restore_valid_out)
        else $error("Restore strobe without a fast return.");
    chk_shadow_private: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE2]
        apb_access && !ctx_save |=> $stable(ctx_status) && $stable(ctx_working)
            && $stable(ctx_bank))
        else $error("Bus access changed the shadow store.");

    // Read mux; unmapped addresses answer with an error and zero data.
    wire [31:0] rd_mux = hit_low ? {24'h00_0000, pc[7:0]} :
        hit_mid ? {24'h00_0000, middle_byte_latch} :
        hit_up ? {27'h000_0000, upper_byte_latch} :
        hit_stat ? {27'h000_0000, exec_valid, instr_valid, phase, 1'b0} :
        hit_instr ? {16'h0000, instr} : 32'h0000_0000;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && !hit_any;
            prdata <= apb_rd ? rd_mux : 32'h0000_0000;
        end
    end

    chk_pready_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    chk_error_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE2]
        pslverr |-> pready)
        else $error("Error flag without ready.");
    chk_mapped_ok: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        apb_access && hit_any |=> !pslverr)
        else $error("Mapped access answered with an error.");
    chk_low_rdata: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        low_read |=> prdata[7:0] == $past(pc[7:0]))
        else $error("Low byte read returned wrong data.");
    chk_mid_rdata: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        apb_rd && hit_mid |=> prdata[7:0] == $past(middle_byte_latch))
        else $error("Middle latch read returned wrong data.");
    chk_up_rdata: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE9]
        apb_rd && hit_up |=> prdata[4:0] == $past(upper_byte_latch))
        else $error("Upper latch read returned wrong data.");
    chk_instr_rdata: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE16]
        apb_rd && hit_instr |=> prdata[15:0] == $past(instr))
        else $error("Instruction read returned wrong data.");

    assign prdata_out = prdata;
    assign pready_out = pready;
    assign pslverr_out = pslverr;
    assign pc_out = pc;
    assign instr_out = instr;
    assign phase_out = phase;
    assign exec_valid_out = exec_valid;
    assign restore_valid_out = ctx_restore_valid;
    assign restore_status_out = ctx_status;
    assign restore_working_out = ctx_working;
    assign restore_bank_out = ctx_bank;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            // Reset parks the phase in phase one, so its flag starts high.
            phase_one_out <= 1'b1;
            phase_four_out <= 1'b0;
        end else begin
            phase_one_out <= (next_phase == PH_ONE);
            phase_four_out <= (next_phase == PH_FOUR);
        end
    end

    chk_phase_cycle: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE15]
        phase == PH_ONE |=> phase == PH_TWO ##1 phase == PH_THREE ##1 phase == PH_FOUR)
        else $error("Phase sequence broken.");
    chk_phase_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE15]
        phase == PH_FOUR |=> phase == PH_ONE)
        else $error("Phase four did not wrap to phase one.");
    chk_phase_one_flag: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE15]
        phase_one_out == (phase == PH_ONE))
        else $error("Phase one flag disagrees with the phase.");
    chk_phase_four_flag: assert property (@(posedge clk_in) disable iff (!resetn_in) // [RULE15]
        phase_four_out == (phase == PH_FOUR))
        else $error("Phase four flag disagrees with the phase.");
endmodule // pc_sequencer

// *** testbench/core_partner.sv ***
// Core-side partner model that feeds fetch words and one-cycle core strobes.
`timescale 1ns/10ps
module core_partner (
    // Clock
    input wire logic clk_in,
    // Requests from the bench and current counter
    input wire logic [3:0] req_in,
    input wire logic [20:0] target_in,
    input wire logic [20:0] pc_in,
    // Strobes and fetch word to the sequencer
    output logic load_pc_out,
    output logic [20:0] load_target_out,
    output logic irq_vector_out,
    output logic fast_call_out,
    output logic fast_return_out,
    output logic [15:0] fetch_word_out
);
    // The word follows the address so that a stale instruction latch shows up.
    assign fetch_word_out = pc_in[16:1] ^ 16'hA5C3;
    // Nested entries are driven on purpose; the bench expects the overwrite.
    always @(posedge clk_in) begin
        load_pc_out <= req_in[0];
        load_target_out <= req_in[0] ? target_in : ~load_target_out;
        irq_vector_out <= req_in[1];
        fast_call_out <= req_in[2];
        fast_return_out <= req_in[3];
    end
endmodule // core_partner

// *** testbench/testbench.sv ***
// Self-checking bench for the program counter sequencer.
`timescale 1ns/10ps
module testbench;
    logic clk_in, resetn_in, psel, penable, pwrite, pready, pslverr;
    logic ld, irq, fcall, fret, ph1, ph4, execv, rvalid, m_ex, m_rv, m_acc, m_iv;
    logic [7:0] paddr, stat, working_register, bank, r_stat, r_working_register, r_bank, m_mid;
    logic [31:0] pwdata, prdata;
    logic [15:0] fword, instr, m_ins, m_rd;
    logic [20:0] target, pc, tgt_req, m_pc;
    logic [1:0] phase, m_ph;
    logic [3:0] req;
    logic [4:0] m_up;
    logic [23:0] m_sh;
    int bad_count, comparisons;
    pc_sequencer dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .fetch_word_in(fword), .load_pc_in(ld), .load_target_in(target),
        .irq_vector_in(irq), .fast_call_in(fcall), .fast_return_in(fret),
        .status_in(stat), .working_register_in(working_register), .bank_select_register_in(bank),
        .pc_out(pc), .instr_out(instr), .phase_out(phase), .phase_one_out(ph1),
        .phase_four_out(ph4), .exec_valid_out(execv), .restore_valid_out(rvalid),
        .restore_status_out(r_stat), .restore_working_out(r_working_register),
        .restore_bank_out(r_bank));
    core_partner partner (.clk_in(clk_in), .req_in(req), .target_in(tgt_req), .pc_in(pc),
        .load_pc_out(ld), .load_target_out(target), .irq_vector_out(irq),
        .fast_call_out(fcall), .fast_return_out(fret), .fetch_word_out(fword));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Reference model of counter, latches, phases and shadow store.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            {m_pc, m_mid, m_up, m_ph, m_ins, m_ex, m_iv, m_rv, m_acc, m_sh} = '0;
        end else begin
            m_rv = fret;
            if (psel && penable && !m_acc) begin
                m_rd = paddr == 8'h04 ? 16'(m_mid) : paddr == 8'h08 ? 16'(m_up) :
                    paddr == 8'h0C ? 16'({m_ex, m_iv, m_ph, 1'b0}) :
                    paddr == 8'h10 ? m_ins : 16'(m_pc[7:0]);
                if (pwrite && paddr == 8'h04) m_mid = pwdata[7:0];
                if (pwrite && paddr == 8'h08) m_up = pwdata[4:0];
                if (!pwrite && paddr == 8'h00) {m_up, m_mid} = m_pc[20:8];
            end
            if (psel && penable && !m_acc && pwrite && paddr == 8'h00)
                m_pc = {m_up, m_mid, pwdata[7:1], 1'b0};
            else if (ld) m_pc = {target[20:1], 1'b0};
            else if (m_ph == 2'h0) m_pc = m_pc + 21'h00_0002;
            m_ex = m_iv;
            if (m_ph == 2'h3) begin
                m_ins = fword;
                m_iv = 1'b1;
            end
            if (irq || fcall) m_sh = {stat, working_register, bank};
            m_acc = psel && penable;
            m_ph = m_ph + 2'h1;
        end
    end
    always @(negedge clk_in) begin
        chk("pc", 32'(pc), 32'(m_pc));
        chk("phase", {ph4, ph1, phase}, {m_ph == 2'h3, m_ph == 2'h0, m_ph});
        chk("instr", 32'(instr), 32'(m_ins));
        chk("exec", 32'(execv), 32'(m_ex));
        chk("restore", 32'(rvalid), 32'(m_rv));
        if (m_rv) chk("shadow", {r_stat, r_working_register, r_bank}, 32'(m_sh));
    end
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        if (!wr) chk("rdata", prdata, addr > 8'h10 ? 32'h0000_0000 : 32'(m_rd));
        chk("slverr", 32'(pslverr), 32'(addr > 8'h10));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic core(input logic [3:0] r, input logic [20:0] t);
        req <= r;
        tgt_req <= t;
        {stat, working_register, bank} <= 24'($urandom);
        @(posedge clk_in);
        req <= 4'h0;
        repeat (5) @(posedge clk_in);
    endtask
    task automatic complete_run();
        if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h6512));
        {resetn_in, psel, penable, pwrite, paddr, pwdata, req, tgt_req, stat, working_register, bank} = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (9) @(posedge clk_in);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 8'h04, i == 0 ? 32'h0000_00FF : $urandom);
            apb(1'b1, 8'h08, i == 0 ? 32'h0000_001F : $urandom);
            apb(1'b1, 8'h00, $urandom | 32'h0000_0001);
            apb(1'b0, 8'h00, 32'h0000_0000);
            apb(1'b0, 8'h04, 32'h0000_0000);
            apb(1'b0, 8'h08, 32'h0000_0000);
            apb(1'b0, 8'h10, 32'h0000_0000);
            apb(1'b0, 8'h0C, 32'h0000_0000);
            apb(1'b0, 8'h14, 32'h0000_0000);
        end
        for (int i = 0; i < 4; i++) begin
            core(4'h1, 21'($urandom));
            core(4'h2, 21'h00_0000);
            core(4'h2, 21'h00_0000);
            core(4'h8, 21'h00_0000);
            core(4'h8, 21'h00_0000);
            core(4'h4, 21'h00_0000);
            core(4'h8, 21'h00_0000);
        end
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        apb(1'b0, 8'h08, 32'h0000_0000);
        complete_run();
    end
    initial begin
        #(40 * 4000);
        bad_count++;
        complete_run();
    end
endmodule // testbench
